//--- logic/dvsc_top.v
// stereo dac volume soft-stepping, power sequencing, driver and short-circuit control
`timescale 1ns/1ps
`include "dvsc_defines.vh"
module dvsc_top #(
	parameter UP_DELAY = 16'd64,
	parameter POP_DELAY = 16'd64
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire sample_strobe,
	input wire signed [15:0] left_in,
	input wire signed [15:0] right_in,
	output reg signed [15:0] left_out,
	output reg signed [15:0] right_out,
	input wire short_detect,
	input wire mixer_on,
	input wire keyclick_on,
	output reg dac_power,
	output wire driver_enable,
	output wire driver_high_power,
	output wire [1:0] output_swing,
	output wire current_limit,
	output wire deemph_enable
);
	localparam ST_OFF = 3'd0;
	localparam ST_UP = 3'd1;
	localparam ST_ON = 3'd2;
	localparam ST_FMUTE = 3'd3;
	localparam ST_FUNMUTE = 3'd4;
	localparam ST_DOWN = 3'd5;
	localparam ST_POP = 3'd6;
	reg [15:0] vol;
	reg slow, deemph, dac_on, effect, hipwr, nostep, prot_auto, prot_off, flag;
	reg [1:0] swing;
	reg [15:0] coef [0:`DVSC_NCOEF-1];
	reg deemph_act, effect_act;
	reg [6:0] appl_l, appl_r;
	reg half;
	reg [2:0] state;
	reg [15:0] timer;
	reg drv_off;
	reg [31:0] rd_word;
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd_setup = psel && !penable && !pwrite;
	wire coef_hit = paddr >= `DVSC_ADDR_COEF && paddr < `DVSC_ADDR_COEF + 8'd80;
	wire [7:0] coef_off = paddr - `DVSC_ADDR_COEF;
	wire [4:0] coef_idx = coef_off[6:2];
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	// mute or forced mute during sequencing overrides the programmed level
	wire force_mute = state != ST_ON && state != ST_FUNMUTE && state != ST_UP;
	wire [6:0] tgt_l = (vol[`DVSC_VOL_LMUTE] || force_mute) ? `DVSC_MUTE_LEVEL : vol[14:8];
	wire [6:0] tgt_r = (vol[`DVSC_VOL_RMUTE] || force_mute) ? `DVSC_MUTE_LEVEL : vol[6:0];
	wire done_l = appl_l == tgt_l;
	wire done_r = appl_r == tgt_r;
	wire at_mute = appl_l == `DVSC_MUTE_LEVEL && appl_r == `DVSC_MUTE_LEVEL;
	wire routing_off = !dac_on && !mixer_on && !keyclick_on;
	wire filt_req = deemph != deemph_act || effect != effect_act;
	// 00 on, 01 up, 10 down, 11 off
	// the host may stop the master clock only once the code reads 11
	wire stat_hi = state == ST_DOWN || state == ST_POP || state == ST_OFF;
	wire stat_lo = state == ST_UP || state == ST_OFF;
	function [6:0] dvsc_step;
		input [6:0] cur;
		input [6:0] tgt;
		begin
			if (cur < tgt)
				dvsc_step = cur + 7'd1;
			else if (cur > tgt)
				dvsc_step = cur - 7'd1;
			else
				dvsc_step = cur;
		end
	endfunction
	// attenuation in 0.375 dB steps: approximated by a 6 dB shift plus linear fraction
	// a coarse law keeps the cost to one 16 by 9 product per channel
	function signed [15:0] dvsc_gain;
		input signed [15:0] s;
		input [6:0] att;
		reg signed [15:0] sh;
		reg signed [23:0] p;
		begin
			sh = s >>> att[6:4];
			p = sh * $signed({1'b0, 8'd255 - {att[3:0], 3'b000}});
			dvsc_gain = (att == `DVSC_MUTE_LEVEL) ? 16'sh0000 : p[23:8];
		end
	endfunction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vol <= `DVSC_VOL_RESET;
			slow <= 1'b0;
			deemph <= 1'b0;
			dac_on <= 1'b0;
			effect <= 1'b0;
			hipwr <= 1'b0;
			nostep <= 1'b0;
			prot_auto <= 1'b0;
			prot_off <= 1'b0;
			swing <= `DVSC_SWING_RESET;
		end else if (wr) begin
			case (paddr)
				`DVSC_ADDR_VOL: vol <= pwdata[15:0];
				`DVSC_ADDR_CTRL: begin
					slow <= pwdata[`DVSC_CTRL_SLOW];
					deemph <= pwdata[`DVSC_CTRL_DEEMPH];
					if (pwdata[`DVSC_CTRL_MASTER])
						vol <= {pwdata[15:8], pwdata[15:8]};
				end
				`DVSC_ADDR_PWR: begin
					dac_on <= pwdata[`DVSC_PWR_DACON];
					effect <= pwdata[`DVSC_PWR_EFFECT];
					hipwr <= pwdata[`DVSC_PWR_HIPWR];
				end
				`DVSC_ADDR_SWING: swing <= pwdata[`DVSC_SWING_HI:`DVSC_SWING_LO];
				`DVSC_ADDR_PROT: begin
					prot_auto <= pwdata[`DVSC_PROT_AUTO];
					prot_off <= pwdata[`DVSC_PROT_OFF];
					nostep <= pwdata[`DVSC_PROT_NOSTEP];
				end
				default: ;
			endcase
		end
	end
	// coefficients stay writable while the filter runs; retuning mid-stream can click
	integer i;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `DVSC_NCOEF; i = i + 1) begin
				case (i % 10)
					0, 3: coef[i] <= `DVSC_COEF_N0;
					1, 4: coef[i] <= `DVSC_COEF_N1;
					2, 5: coef[i] <= `DVSC_COEF_N2;
					6, 8: coef[i] <= `DVSC_COEF_D1;
					default: coef[i] <= `DVSC_COEF_D2;
				endcase
			end
		end else if (wr && coef_hit) begin
			coef[coef_idx] <= pwdata[15:0];
		end
	end
	always @* begin
		rd_word = 32'h0000_0000;
		if (coef_hit)
			rd_word = {16'h0000, coef[coef_idx]};
		else case (paddr)
			`DVSC_ADDR_VOL: rd_word = {16'h0000, vol};
			`DVSC_ADDR_CTRL: rd_word = {27'h0, deemph, done_r, done_l, slow, 1'b0};
			`DVSC_ADDR_PWR: rd_word = {19'h0, hipwr, 1'b0, stat_hi, 3'h0, stat_lo,
				4'h0, effect, dac_on};
			`DVSC_ADDR_SWING: rd_word = {21'h0, swing, 9'h0};
			`DVSC_ADDR_PROT: rd_word = {17'h0, nostep, 5'h0, prot_off, prot_auto,
				flag, 6'h0};
			default: rd_word = 32'h0000_0000;
		endcase
	end
	// read data is taken in the setup cycle so the access phase sees a flop, not a mux;
	// status bits are therefore one cycle old when the host samples them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= rd_word;
		else
			prdata <= 32'h0000_0000;
	end
	// step on every sample, or every second one in slow mode
	wire step_now = sample_strobe && (!slow || half);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			appl_l <= `DVSC_MUTE_LEVEL;
			appl_r <= `DVSC_MUTE_LEVEL;
			half <= 1'b0;
		end else begin
			if (sample_strobe)
				half <= !half;
			if (nostep) begin
				appl_l <= tgt_l;
				appl_r <= tgt_r;
			end else if (step_now) begin
				appl_l <= dvsc_step(appl_l, tgt_l);
				appl_r <= dvsc_step(appl_r, tgt_r);
			end
		end
	end
	// power and filter-change sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_OFF;
			timer <= 16'h0000;
			dac_power <= 1'b0;
			deemph_act <= 1'b0;
			effect_act <= 1'b0;
		end else begin
			case (state)
				ST_OFF: begin
					if (dac_on) begin
						state <= ST_UP;
						dac_power <= 1'b1;
						timer <= UP_DELAY;
						deemph_act <= deemph;
						effect_act <= effect;
					end
				end
				ST_UP: begin
					// powering-up holds for the driver delay; a dac_on drop is
					// only honoured once the delay has run out
					if (timer != 16'h0000)
						timer <= timer - 16'd1;
					else
						state <= ST_ON;
				end
				ST_ON: begin
					if (!dac_on)
						state <= ST_DOWN;
					else if (filt_req)
						state <= ST_FMUTE;
				end
				ST_FMUTE: begin
					if (at_mute) begin
						deemph_act <= deemph;
						effect_act <= effect;
						state <= ST_FUNMUTE;
					end
				end
				ST_FUNMUTE: begin
					if (!dac_on)
						state <= ST_DOWN;
					else if (filt_req)
						state <= ST_FMUTE;
					else if (done_l && done_r)
						state <= ST_ON;
				end
				ST_DOWN: begin
					if (at_mute) begin
						state <= ST_POP;
						timer <= POP_DELAY;
					end
				end
				ST_POP: begin
					if (timer != 16'h0000)
						timer <= timer - 16'd1;
					else begin
						state <= ST_OFF;
						dac_power <= 1'b0;
					end
				end
				default: state <= ST_OFF;
			endcase
		end
	end
	// short-circuit flag and auto powerdown; a live short keeps the flag set
	// a short seen in the cycle of the routing release keeps the flag: set wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
			drv_off <= 1'b0;
		end else if (prot_off) begin
			flag <= 1'b0;
			drv_off <= 1'b0;
		end else if (short_detect) begin
			flag <= 1'b1;
			if (prot_auto)
				drv_off <= 1'b1;
		end else if (prot_auto) begin
			if (routing_off) begin
				flag <= 1'b0;
				drv_off <= 1'b0;
			end
		end else begin
			flag <= 1'b0;
			drv_off <= 1'b0;
		end
	end
	assign driver_enable = !drv_off && (dac_power || mixer_on || keyclick_on);
	assign driver_high_power = hipwr;
	assign output_swing = swing;
	assign current_limit = !prot_off && !prot_auto;
	assign deemph_enable = deemph_act;
	wire [159:0] coef_l = {coef[9], coef[8], coef[7], coef[6], coef[5], coef[4],
		coef[3], coef[2], coef[1], coef[0]};
	wire [159:0] coef_r = {coef[19], coef[18], coef[17], coef[16], coef[15], coef[14],
		coef[13], coef[12], coef[11], coef[10]};
	wire signed [15:0] filt_l, filt_r;
	dvsc_biquad u_biquad_l (
		.pclk(pclk),
		.presetn(presetn),
		.sample_strobe(sample_strobe),
		.sample_in(left_in),
		.coef(coef_l),
		.sample_out(filt_l)
	);
	dvsc_biquad u_biquad_r (
		.pclk(pclk),
		.presetn(presetn),
		.sample_strobe(sample_strobe),
		.sample_in(right_in),
		.coef(coef_r),
		.sample_out(filt_r)
	);
	// the filter output lags one sample; bypass uses the raw input
	wire signed [15:0] src_l = effect_act ? filt_l : left_in;
	wire signed [15:0] src_r = effect_act ? filt_r : right_in;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_out <= 16'h0000;
			right_out <= 16'h0000;
		end else if (sample_strobe) begin
			left_out <= dac_power ? dvsc_gain(src_l, appl_l) : 16'sh0000;
			right_out <= dac_power ? dvsc_gain(src_r, appl_r) : 16'sh0000;
		end
	end
endmodule

//--- logic/dvsc_defines.vh
// register offsets, field positions, reset values and coefficient defaults for the volume block
`ifndef DVSC_DEFINES_VH
`define DVSC_DEFINES_VH
// byte addresses of the 32-bit apb words (printed indices times four)
`define DVSC_IDX_VOL 6'h02
`define DVSC_IDX_CTRL 6'h04
`define DVSC_IDX_PWR 6'h05
`define DVSC_IDX_SWING 6'h06
`define DVSC_IDX_PROT 6'h1d
`define DVSC_IDX_COEF 6'h20
`define DVSC_ADDR_VOL 8'h08
`define DVSC_ADDR_CTRL 8'h10
`define DVSC_ADDR_PWR 8'h14
`define DVSC_ADDR_SWING 8'h18
`define DVSC_ADDR_PROT 8'h74
// coefficient window: 0x80 + 4*k, k = chan*10 + index (n0..n5,d1,d2,d4,d5)
`define DVSC_ADDR_COEF 8'h80
`define DVSC_NCOEF 20
// volume word: left mute 15, left att 14:8, right mute 7, right att 6:0
`define DVSC_VOL_LMUTE 15
`define DVSC_VOL_RMUTE 7
`define DVSC_VOL_RESET 16'hffff
// ctrl: master write 16 writes both channels, slow step 1, done 3:2, deemph 4
`define DVSC_CTRL_SLOW 1
`define DVSC_CTRL_DONE_L 2
`define DVSC_CTRL_DONE_R 3
`define DVSC_CTRL_DEEMPH 4
`define DVSC_CTRL_MASTER 16
// pwr: dac power 0, effects 1, status 6 and 10, high power 12
`define DVSC_PWR_DACON 0
`define DVSC_PWR_EFFECT 1
`define DVSC_PWR_STAT_LO 6
`define DVSC_PWR_STAT_HI 10
`define DVSC_PWR_HIPWR 12
// swing 10:9
`define DVSC_SWING_LO 9
`define DVSC_SWING_HI 10
`define DVSC_SWING_RESET 2'h0
// prot: flag 6, auto powerdown 7, disable 8, no soft-step 14
`define DVSC_PROT_FLAG 6
`define DVSC_PROT_AUTO 7
`define DVSC_PROT_OFF 8
`define DVSC_PROT_NOSTEP 14
`define DVSC_MUTE_LEVEL 7'h7f
`define DVSC_MAX_ATT 7'h7f
`define DVSC_COEF_N0 16'h6be3
`define DVSC_COEF_N1 16'h9666
`define DVSC_COEF_N2 16'h675d
`define DVSC_COEF_D1 16'h7d83
`define DVSC_COEF_D2 16'h84ee
`define DVSC_FILT_SHIFT 15
`endif

//--- logic/dvsc_biquad.v
// two cascaded biquad sections for one channel, one sample per strobe
`timescale 1ns/1ps
module dvsc_biquad (
	input wire pclk,
	input wire presetn,
	input wire sample_strobe,
	input wire signed [15:0] sample_in,
	input wire [159:0] coef,
	output reg signed [15:0] sample_out
);
	reg signed [15:0] x1, x2, y1, y2, z1, z2;
	wire signed [15:0] n0 = coef[15:0];
	wire signed [15:0] n1 = coef[31:16];
	wire signed [15:0] n2 = coef[47:32];
	wire signed [15:0] n3 = coef[63:48];
	wire signed [15:0] n4 = coef[79:64];
	wire signed [15:0] n5 = coef[95:80];
	wire signed [15:0] d1 = coef[111:96];
	wire signed [15:0] d2 = coef[127:112];
	wire signed [15:0] d4 = coef[143:128];
	wire signed [15:0] d5 = coef[159:144];
	// saturating divide by the 32768 denominator constant
	function signed [15:0] dvsc_norm;
		input signed [39:0] acc;
		reg signed [39:0] q;
		begin
			q = acc >>> `DVSC_FILT_SHIFT;
			if (q > 40'sd32767)
				dvsc_norm = 16'sh7fff;
			else if (q < -40'sd32768)
				dvsc_norm = -16'sh8000;
			else
				dvsc_norm = q[15:0];
		end
	endfunction
	// y = (n0 x + 2 n1 x1 + n2 x2 + 2 d1 y1 + d2 y2) / 32768
	function signed [15:0] dvsc_section;
		input signed [15:0] x0, xa, xb, ya, yb, c0, c1, c2, e1, e2;
		reg signed [39:0] acc;
		begin
			acc = x0 * c0 + 2 * xa * c1 + xb * c2 + 2 * ya * e1 + yb * e2;
			dvsc_section = dvsc_norm(acc);
		end
	endfunction
	wire signed [15:0] stage1 = dvsc_section(sample_in, x1, x2, y1, y2, n0, n1, n2, d1, d2);
	wire signed [15:0] stage2 = dvsc_section(stage1, y1, y2, z1, z2, n3, n4, n5, d4, d5);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x1 <= 16'h0000;
			x2 <= 16'h0000;
			y1 <= 16'h0000;
			y2 <= 16'h0000;
			z1 <= 16'h0000;
			z2 <= 16'h0000;
			sample_out <= 16'h0000;
		end else if (sample_strobe) begin
			x1 <= sample_in;
			x2 <= x1;
			y1 <= stage1;
			y2 <= y1;
			z1 <= stage2;
			z2 <= z1;
			sample_out <= stage2;
		end
	end
endmodule

//--- verification/dvsc_chk_sva.sv
// port-level assertion checker for the volume control block
`timescale 1ns/1ps
`include "dvsc_defines.vh"
module dvsc_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire sample_strobe,
	input wire signed [15:0] left_out,
	input wire signed [15:0] right_out,
	input wire short_detect,
	input wire dac_power,
	input wire driver_enable,
	input wire driver_high_power,
	input wire [1:0] output_swing,
	input wire current_limit
);
reg hp;
reg off;
reg aut;
reg [1:0] sw;
wire wr = psel && penable && pwrite;
// shadow copies of the driver and protection settings, tracked from bus writes
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		hp <= 1'b0;
		off <= 1'b0;
		aut <= 1'b0;
		sw <= 2'h0;
	end else if (wr && paddr == `DVSC_ADDR_PWR) begin
		hp <= pwdata[`DVSC_PWR_HIPWR];
	end else if (wr && paddr == `DVSC_ADDR_SWING) begin
		sw <= pwdata[10:9];
	end else if (wr && paddr == `DVSC_ADDR_PROT) begin
		off <= pwdata[`DVSC_PROT_OFF];
		aut <= pwdata[`DVSC_PROT_AUTO];
	end
end
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
property p_hold_l; !sample_strobe |=> $stable(left_out); endproperty
a_hold_l: assert property (p_hold_l) else $error("left out moved between samples");
property p_hold_r; !sample_strobe |=> $stable(right_out); endproperty
a_hold_r: assert property (p_hold_r) else $error("right out moved between samples");
property p_mute; sample_strobe && !dac_power |=> left_out == 16'sh0 && right_out == 16'sh0;
endproperty
a_mute: assert property (p_mute) else $error("output not silent while powered off");
property p_rd; !(psel && penable && !pwrite) |-> prdata == 32'h0; endproperty
a_rd: assert property (p_rd) else $error("read data outside read access");
property p_hp; driver_high_power == hp; endproperty
a_hp: assert property (p_hp) else $error("driver power mode mismatch");
property p_sw; output_swing == sw; endproperty
a_sw: assert property (p_sw) else $error("output swing mismatch");
property p_cl; current_limit == (!off && !aut); endproperty
a_cl: assert property (p_cl) else $error("current limit mode mismatch");
property p_auto; short_detect && aut && !off |-> ##[1:2] !driver_enable; endproperty
a_auto: assert property (p_auto) else $error("drivers kept on during short");
endmodule
bind dvsc_top dvsc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.sample_strobe(sample_strobe), .left_out(left_out), .right_out(right_out),
	.short_detect(short_detect), .dac_power(dac_power), .driver_enable(driver_enable),
	.driver_high_power(driver_high_power), .output_swing(output_swing),
	.current_limit(current_limit));

//--- verification/dvsc_src.sv
// sample source model: one strobe and a stereo pair per sample period
`timescale 1ns/1ps
module dvsc_src #(
	parameter PERIOD = 8
) (
	input wire pclk,
	input wire presetn,
	output reg sample_strobe,
	output reg signed [15:0] left_in,
	output reg signed [15:0] right_in
);
reg [7:0] cnt;
// one pulse per sample, data changed only with the strobe
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt <= 8'h0;
		sample_strobe <= 1'b0;
		left_in <= 16'sh4000;
		right_in <= 16'sh2000;
	end else begin
		cnt <= (cnt == PERIOD - 1) ? 8'h0 : cnt + 8'h1;
		sample_strobe <= (cnt == PERIOD - 1);
		if (cnt == PERIOD - 1) begin
			left_in <= left_in ^ 16'sh0100;
			right_in <= right_in ^ 16'sh0100;
		end
	end
end
endmodule

//--- verification/testbench.sv
// self-checking bench for the volume control block
`timescale 1ns/1ps
`include "dvsc_defines.vh"
module testbench;
reg pclk, presetn, psel, penable, pwrite, short_detect, mixer_on, keyclick_on;
reg [7:0] paddr;
reg [31:0] pwdata;
reg [31:0] rd;
wire [31:0] prdata;
wire pready, pslverr, sample_strobe, dac_power, driver_enable, driver_high_power;
wire current_limit, deemph_enable;
wire signed [15:0] left_in, right_in, left_out, right_out;
wire [1:0] output_swing;
integer fail_count, checks_done, nstrb, n0, i;
dvsc_src #(.PERIOD(8)) u_src (.pclk(pclk), .presetn(presetn),
	.sample_strobe(sample_strobe), .left_in(left_in), .right_in(right_in));
// short power-up and pop delays keep the power sequence brief
dvsc_top #(.UP_DELAY(16'd4), .POP_DELAY(16'd4)) uut (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_strobe(sample_strobe),
	.left_in(left_in), .right_in(right_in), .left_out(left_out), .right_out(right_out),
	.short_detect(short_detect), .mixer_on(mixer_on), .keyclick_on(keyclick_on),
	.dac_power(dac_power), .driver_enable(driver_enable),
	.driver_high_power(driver_high_power), .output_swing(output_swing),
	.current_limit(current_limit), .deemph_enable(deemph_enable));
initial begin
	pclk = 1'b0;
	forever #25 pclk = ~pclk;
end
always @(posedge pclk) begin
	if (sample_strobe === 1'b1) nstrb <= nstrb + 1;
end
task end_sim;
	begin
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	end
endtask
task chk(input [31:0] got, input [31:0] exp, input string msg);
	begin
		checks_done = checks_done + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	end
endtask
// one apb transfer; the setup cycle is always preceded by an idle edge
task apb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	end
endtask
task poll(input [7:0] a, input [31:0] m, input [31:0] v);
	integer n;
	begin
		n = 0;
		apb(1'b0, a, 32'h0);
		while ((rd & m) !== v && n < 600) begin
			apb(1'b0, a, 32'h0);
			n = n + 1;
		end
		chk(rd & m, v, "poll");
	end
endtask
task steps(input integer lo, input integer hi);
	begin
		n0 = nstrb;
		poll(`DVSC_ADDR_CTRL, 32'hc, 32'hc);
		chk(nstrb - n0 >= lo && nstrb - n0 <= hi, 1, "step count");
	end
endtask
initial begin
	{presetn, psel, penable, pwrite, short_detect} = 5'h0;
	{mixer_on, keyclick_on} = 2'b11;
	paddr = 8'h0;
	pwdata = 32'h0;
	{fail_count, checks_done, nstrb} = 0;
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	apb(1'b0, `DVSC_ADDR_VOL, 32'h0);
	chk(rd[15:0], 16'hffff, "vol reset");
	apb(1'b0, `DVSC_ADDR_PWR, 32'h0);
	chk({rd[10], rd[6], rd[12]}, 3'b110, "pwr reset");
	apb(1'b0, `DVSC_ADDR_SWING, 32'h0);
	chk(rd[10:9], 2'h0, "swing reset");
	apb(1'b0, 8'h7c, 32'h0);
	chk(rd, 32'h0, "unmapped");
	chk(pslverr, 1'b0, "no bus error");
	$display("test reset done");
	apb(1'b1, `DVSC_ADDR_PWR, 32'h1);
	apb(1'b0, `DVSC_ADDR_PWR, 32'h0);
	chk({rd[10], rd[6]}, 2'b01, "powering up");
	poll(`DVSC_ADDR_PWR, 32'h440, 32'h0);
	chk(dac_power, 1, "dac power");
	apb(1'b1, `DVSC_ADDR_VOL, 32'h0010);
	apb(1'b0, `DVSC_ADDR_CTRL, 32'h0);
	chk(rd[3:2], 2'b00, "done early");
	steps(126, 128);
	chk(left_out != 16'sh0, 1, "audible");
	$display("test powerup ramp done");
	// counting starts at the write edge so the first slow step is never missed
	apb(1'b1, `DVSC_ADDR_CTRL, 32'h00010a02);
	steps(19, 21);
	apb(1'b0, `DVSC_ADDR_VOL, 32'h0);
	chk(rd[15:0], 16'h0a0a, "master");
	apb(1'b1, `DVSC_ADDR_CTRL, 32'h0);
	apb(1'b1, `DVSC_ADDR_VOL, 32'h4040);
	n0 = nstrb + 10;
	while (nstrb < n0) @(posedge pclk);
	apb(1'b1, `DVSC_ADDR_VOL, 32'h0a0a);
	steps(1, 14);
	$display("test stepping done");
	apb(1'b1, `DVSC_ADDR_PROT, 32'h4000);
	apb(1'b1, `DVSC_ADDR_VOL, 32'h3030);
	apb(1'b0, `DVSC_ADDR_CTRL, 32'h0);
	chk(rd[3:2], 2'b11, "no step");
	apb(1'b1, `DVSC_ADDR_VOL, 32'h8000);
	n0 = nstrb + 2;
	while (nstrb < n0) @(posedge pclk);
	@(posedge pclk);
	chk(left_out, 16'h0, "left muted");
	chk(right_out != 16'sh0, 1, "right live");
	apb(1'b1, `DVSC_ADDR_CTRL, 32'h10);
	i = 0;
	while (deemph_enable !== 1'b1 && i < 300) begin
		@(posedge pclk);
		i = i + 1;
	end
	chk(deemph_enable, 1, "deemph");
	apb(1'b1, `DVSC_ADDR_SWING, 32'h600);
	@(posedge pclk);
	chk(output_swing, 2'b11, "swing");
	apb(1'b1, `DVSC_ADDR_PWR, 32'h1001);
	@(posedge pclk);
	chk(driver_high_power, 1, "high power");
	// zero the left second section so the filtered left path must fall silent
	apb(1'b1, `DVSC_ADDR_VOL, 32'h0);
	for (i = 3; i < 10; i = i + 1) begin
		if (i < 6 || i > 7) apb(1'b1, `DVSC_ADDR_COEF + {i[5:0], 2'b00}, 32'h0);
	end
	apb(1'b0, `DVSC_ADDR_COEF, 32'h0);
	chk(rd, {16'h0, `DVSC_COEF_N0}, "coef default");
	apb(1'b0, 8'ha4, 32'h0);
	chk(rd, 32'h0, "coef written");
	n0 = nstrb + 2;
	while (nstrb < n0) @(posedge pclk);
	@(posedge pclk);
	chk(left_out != 16'sh0, 1, "bypass live");
	apb(1'b1, `DVSC_ADDR_PWR, 32'h1003);
	n0 = nstrb + 4;
	while (nstrb < n0) @(posedge pclk);
	@(posedge pclk);
	chk({left_out == 16'sh0, right_out != 16'sh0}, 2'b11, "filter in path");
	$display("test settings done");
	chk(current_limit, 1, "limit mode");
	short_detect <= 1'b1;
	apb(1'b0, `DVSC_ADDR_PROT, 32'h0);
	chk(rd[6], 1, "flag set");
	short_detect <= 1'b0;
	apb(1'b0, `DVSC_ADDR_PROT, 32'h0);
	chk(rd[6], 0, "flag clear");
	apb(1'b1, `DVSC_ADDR_PROT, 32'h4100);
	short_detect <= 1'b1;
	apb(1'b0, `DVSC_ADDR_PROT, 32'h0);
	chk(rd[6], 0, "disabled");
	short_detect <= 1'b0;
	apb(1'b1, `DVSC_ADDR_PROT, 32'h4080);
	short_detect <= 1'b1;
	apb(1'b0, `DVSC_ADDR_PROT, 32'h0);
	chk({rd[6], driver_enable}, 2'b10, "auto off");
	short_detect <= 1'b0;
	apb(1'b0, `DVSC_ADDR_PROT, 32'h0);
	chk(rd[6], 1, "flag held");
	{mixer_on, keyclick_on} <= 2'b00;
	apb(1'b1, `DVSC_ADDR_PWR, 32'h0);
	// the clock keeps running until the off code has been read back
	poll(`DVSC_ADDR_PWR, 32'h440, 32'h440);
	chk(dac_power, 0, "powered off");
	apb(1'b0, `DVSC_ADDR_PROT, 32'h0);
	chk(rd[6], 0, "flag released");
	$display("test protection done");
	end_sim;
end
initial begin
	#2000000;
	fail_count = fail_count + 1;
	$display("[FAIL] %0t watchdog expired", $time);
	end_sim;
end
endmodule
